// ==== tnr_reg_bank.sv ====
// apb register bank of a token passing node controller
//
// Behaviour
// RQ1: host writes zero to undefined bits
// RQ2: offset 0 mask/status, 1 command/diagnostic
// RQ3: mask bit aligns with its flag
// RQ4: interrupt is OR of masked flags
// RQ5: only five flags may interrupt
// RQ6: masking hides, unmasking restores pending interrupt
// RQ7: clear flags command clears recon
// RQ8: excessive nak cleared only by por clear; the code also clears it on soft reset
// RQ9: successor read clears new successor flag
// RQ10: mask resets to zero
// RQ11: data port moves bytes at pointer
// RQ12: data loaded on low pointer write
// RQ13: probe identity sets tentative flag on hit
// RQ14: probe and own identity hardware reset zero
// RQ15: zero own identity keeps core dormant
// RQ16: core joins only with transmit enable
// RQ17: successor register holds token target
// RQ18: successor update sets new successor flag
// RQ19: successor resets on both resets
// RQ20: status resets to 1xx1 0001
// RQ21: diagnostic read clears most flags
// RQ22: diagnostic resets to zero
// RQ23: high pointer before low, low loads
// RQ24: three bit select picks window register
`timescale 1ns/1ps
module tnr_reg_bank #(
  parameter int ADDR_W = 12,
  parameter int RAM_AW = 11
) (
  input  wire logic                  pclk,      // bus clock
  input  wire logic                  presetn,   // async reset, low
  input  wire logic                  psel,      // apb select
  input  wire logic                  penable,   // apb enable
  input  wire logic                  pwrite,    // apb direction
  input  wire logic [ADDR_W-1:0]     paddr,     // apb byte address
  input  wire logic [31:0]           pwdata,    // apb write data
  output      logic [31:0]           prdata,    // apb read data
  output      logic                  pready,    // apb ready
  output      logic                  pslverr,   // apb error
  input  wire tnr_pkg::tnr_core_evt_t core_evt, // core events
  output      tnr_pkg::tnr_core_ctl_t core_ctl, // core settings
  output      logic                  intr       // interrupt, high
);

  // ==========================================================
  // state
  logic [7:0]        imask;
  logic [7:0]        diag;
  logic [7:0]        next_diag;
  logic              ri;
  logic              ta;
  logic              recon;
  logic              por;
  logic [7:0]        successor;
  logic [7:0]        probe_id;
  logic [7:0]        own_id;
  logic [7:0]        speed_setup_one;
  logic [7:0]        timing_setup_two;
  logic [7:2]        cfg;
  logic [2:0]        wsel;
  logic [1:0]        wsel_top;
  logic [7:0]        ptr_hi;
  logic [RAM_AW-1:0] addr;
  logic [7:0]        data_reg;
  logic [1:0]        fetch;
  logic [7:0]        ram_rdata;
  logic              wake;
  logic              join_net;
  logic              cmd_valid;
  logic [7:0]        cmd;
  logic              hit;
  logic [2:0]        idx;
  logic              acc;
  logic              wr_en;
  logic              rd_en;
  logic              soft_rst;
  logic              clr_flags;
  logic              por_clr;
  logic              next_rd;
  logic              diag_rd;
  logic              lo_wr;
  logic              data_wr;
  logic              data_rd;
  logic [7:0]        status_vec;
  logic [7:0]        irq_src;
  logic [7:0]        next_rdata;

  // true when the access addresses the given register
  function automatic logic at(input logic [2:0] a, input logic [2:0] b);
    return a == b;
  endfunction

  // ==========================================================
  // bus decode
  always_comb begin
    hit = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:5] == '0);
    idx = paddr[4:2];
  end

  // one wait state, effects happen at the ready edge
  assign acc       = psel & penable & pready;
  assign wr_en     = acc & pwrite & hit;
  assign rd_en     = acc & ~pwrite & hit;
  assign soft_rst  = cfg[tnr_pkg::CFG_RESET];
  assign clr_flags = wr_en & at(idx, tnr_pkg::IDX_CMD_DIAG)
                   & (pwdata[7:0] == tnr_pkg::CMD_CLR_FLG);
  assign por_clr   = wr_en & at(idx, tnr_pkg::IDX_CMD_DIAG)
                   & (pwdata[7:0] == tnr_pkg::CMD_POR_CLR);
  assign diag_rd   = rd_en & at(idx, tnr_pkg::IDX_CMD_DIAG);
  assign next_rd   = rd_en & at(idx, tnr_pkg::IDX_WINDOW)
                   & at(wsel, tnr_pkg::WIN_NEXT);
  assign lo_wr     = wr_en & at(idx, tnr_pkg::IDX_PTR_LO);
  assign data_wr   = wr_en & at(idx, tnr_pkg::IDX_DATA);
  assign data_rd   = rd_en & at(idx, tnr_pkg::IDX_DATA);

  // ready and error handshake
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~hit;
    end
  end

  // ==========================================================
  // read data, undefined bits read zero
  always_comb begin
    status_vec = 8'h00;
    status_vec[tnr_pkg::ST_RI]    = ri;
    status_vec[tnr_pkg::ST_POR]   = por;
    status_vec[tnr_pkg::ST_RECON] = recon;
    status_vec[tnr_pkg::ST_TMA]   = core_evt.tma;
    status_vec[tnr_pkg::ST_TA]    = ta;
    next_rdata = 8'h00;
    case (idx)
      tnr_pkg::IDX_MASK_STAT: next_rdata = status_vec; // RQ2
      tnr_pkg::IDX_CMD_DIAG:  next_rdata = diag; // RQ2
      tnr_pkg::IDX_PTR_HI:
        next_rdata = {ptr_hi[7:3], addr[RAM_AW-1:8]};
      tnr_pkg::IDX_PTR_LO:    next_rdata = addr[7:0];
      tnr_pkg::IDX_DATA:      next_rdata = fetch[1] ? ram_rdata
                                                    : data_reg; // RQ11
      tnr_pkg::IDX_WSEL:      next_rdata = {wsel_top, 3'h0, wsel};
      tnr_pkg::IDX_CONFIG:    next_rdata = {cfg, wsel[1:0]};
      tnr_pkg::IDX_WINDOW: begin
        case (wsel) // RQ24
          tnr_pkg::WIN_PROBE:  next_rdata = probe_id;
          tnr_pkg::WIN_OWN:    next_rdata = own_id;
          tnr_pkg::WIN_SPEED_SETUP_ONE: next_rdata = speed_setup_one;
          tnr_pkg::WIN_NEXT:   next_rdata = successor; // RQ17
          tnr_pkg::WIN_TIMING_SETUP_TWO: next_rdata = timing_setup_two;
          default:             next_rdata = 8'h00;
        endcase
      end
      default: next_rdata = 8'h00;
    endcase
  end

  // read data register, captured as ready rises
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel & penable & ~pready & ~pwrite) begin
      prdata <= hit ? {24'h00_0000, next_rdata} : 32'h0000_0000;
    end
  end

  // ==========================================================
  // interrupt mask and combining
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      imask <= tnr_pkg::ZERO8; // RQ10
    end else if (wr_en & at(idx, tnr_pkg::IDX_MASK_STAT)) begin
      imask <= pwdata[7:0] & tnr_pkg::IRQ_BITS; // RQ1
    end
  end

  // flags at the same positions as their mask bits
  always_comb begin
    irq_src = 8'h00;
    irq_src[tnr_pkg::ST_RI]      = ri; // RQ3
    irq_src[tnr_pkg::DG_EXCESSIVE_NAK_FLAG]  = diag[tnr_pkg::DG_EXCESSIVE_NAK_FLAG];
    irq_src[tnr_pkg::ST_RECON]   = recon;
    irq_src[tnr_pkg::DG_NEWNEXT] = diag[tnr_pkg::DG_NEWNEXT];
    irq_src[tnr_pkg::ST_TA]      = ta;
  end

  // masked flags ORed, mask only hides the level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      intr <= 1'b0;
    end else begin
      intr <= |(irq_src & imask & tnr_pkg::IRQ_BITS); // RQ4 RQ5 RQ6
    end
  end

  // ==========================================================
  // status flags, set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ri    <= tnr_pkg::STATUS_RST[tnr_pkg::ST_RI]; // RQ20
      por   <= tnr_pkg::STATUS_RST[tnr_pkg::ST_POR];
      recon <= tnr_pkg::STATUS_RST[tnr_pkg::ST_RECON];
      ta    <= tnr_pkg::STATUS_RST[tnr_pkg::ST_TA];
    end else if (soft_rst) begin
      ri    <= tnr_pkg::STATUS_RST[tnr_pkg::ST_RI]; // RQ20
      por   <= tnr_pkg::STATUS_RST[tnr_pkg::ST_POR];
      recon <= tnr_pkg::STATUS_RST[tnr_pkg::ST_RECON];
      ta    <= tnr_pkg::STATUS_RST[tnr_pkg::ST_TA];
    end else begin
      ri    <= core_evt.ri_set | (ri & ~core_evt.ri_clr);
      ta    <= core_evt.ta_set | (ta & ~core_evt.ta_clr);
      recon <= core_evt.recon
             | (recon & ~clr_flags & ~por_clr); // RQ7
      por   <= (wr_en & at(idx, tnr_pkg::IDX_WINDOW)
              & at(wsel, tnr_pkg::WIN_OWN) & (pwdata[7:0] == 8'h00))
             | (por & ~clr_flags & ~por_clr);
    end
  end

  // ==========================================================
  // diagnostic flags: clears first, then sets
  always_comb begin
    next_diag = diag;
    if (diag_rd) begin
      next_diag = diag & ~tnr_pkg::DIAG_RD_CLR; // RQ21
    end
    if (por_clr) begin
      next_diag[tnr_pkg::DG_EXCESSIVE_NAK_FLAG] = 1'b0; // RQ8
    end
    if (next_rd) begin
      next_diag[tnr_pkg::DG_NEWNEXT] = 1'b0; // RQ9
    end
    next_diag[tnr_pkg::DG_MYRECON] = next_diag[tnr_pkg::DG_MYRECON]
                                   | core_evt.myrecon;
    next_diag[tnr_pkg::DG_DUPLICATE_IDENTITY_FLAG]   = next_diag[tnr_pkg::DG_DUPLICATE_IDENTITY_FLAG]
                                   | core_evt.duplicate_identity_flag;
    next_diag[tnr_pkg::DG_RCVACT]  = next_diag[tnr_pkg::DG_RCVACT]
                                   | core_evt.rcvact;
    next_diag[tnr_pkg::DG_TOKEN]   = next_diag[tnr_pkg::DG_TOKEN]
                                   | core_evt.token;
    next_diag[tnr_pkg::DG_EXCESSIVE_NAK_FLAG]  = next_diag[tnr_pkg::DG_EXCESSIVE_NAK_FLAG]
                                   | core_evt.excessive_nak_flag;
    next_diag[tnr_pkg::DG_TENT]    = next_diag[tnr_pkg::DG_TENT]
                                   | core_evt.tent_hit; // RQ13
    next_diag[tnr_pkg::DG_NEWNEXT] = next_diag[tnr_pkg::DG_NEWNEXT]
                                   | core_evt.next_upd; // RQ18
    next_diag[0] = 1'b0;
  end

  // diagnostic register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      diag <= tnr_pkg::DIAG_RST; // RQ22
    end else if (soft_rst) begin
      diag <= tnr_pkg::DIAG_RST; // RQ22 RQ8
    end else begin
      diag <= next_diag;
    end
  end

  // successor identity, written by the core
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      successor <= tnr_pkg::ZERO8; // RQ19
    end else if (soft_rst) begin
      successor <= tnr_pkg::ZERO8; // RQ19
    end else if (core_evt.next_upd) begin
      successor <= core_evt.successor_identity; // RQ17
    end
  end

  // ==========================================================
  // identities and setup registers, hardware reset only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      probe_id <= tnr_pkg::ZERO8; // RQ14
      own_id   <= tnr_pkg::ZERO8; // RQ14
      speed_setup_one   <= tnr_pkg::ZERO8;
      timing_setup_two   <= tnr_pkg::ZERO8;
    end else if (wr_en & at(idx, tnr_pkg::IDX_WINDOW)) begin
      case (wsel) // RQ24
        tnr_pkg::WIN_PROBE:  probe_id <= pwdata[7:0]; // RQ13
        tnr_pkg::WIN_OWN:    own_id   <= pwdata[7:0];
        tnr_pkg::WIN_SPEED_SETUP_ONE: speed_setup_one   <= pwdata[7:0];
        tnr_pkg::WIN_TIMING_SETUP_TWO: timing_setup_two   <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // configuration and window select share the low bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg      <= tnr_pkg::CONFIG_RST[7:2];
      wsel     <= {1'b0, tnr_pkg::CONFIG_RST[1:0]};
      wsel_top <= 2'h0;
    end else if (wr_en & at(idx, tnr_pkg::IDX_CONFIG)) begin
      cfg  <= pwdata[7:2];
      wsel <= {1'b0, pwdata[1:0]}; // RQ24
    end else if (wr_en & at(idx, tnr_pkg::IDX_WSEL)) begin
      wsel     <= pwdata[2:0]; // RQ24
      wsel_top <= pwdata[7:6];
    end
  end

  // ==========================================================
  // ram pointer, loaded by the low byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_hi <= tnr_pkg::ZERO8;
      addr   <= '0;
    end else if (wr_en & at(idx, tnr_pkg::IDX_PTR_HI)) begin
      ptr_hi <= pwdata[7:0];
    end else if (lo_wr) begin
      addr <= {ptr_hi[RAM_AW-9:0], pwdata[7:0]}; // RQ23
    end else if ((data_wr | data_rd) & ptr_hi[tnr_pkg::PTR_INC]) begin
      addr <= addr + RAM_AW'(1'b1);
    end
  end

  // fetch pipeline feeding the data port
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fetch <= tnr_pkg::FETCH_IDLE;
    end else begin
      fetch <= {fetch[0], lo_wr
                | (data_rd & ptr_hi[tnr_pkg::PTR_INC])}; // RQ12
    end
  end

  // data port register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_reg <= tnr_pkg::ZERO8;
    end else if (data_wr) begin
      data_reg <= pwdata[7:0];
    end else if (fetch[1]) begin
      data_reg <= ram_rdata; // RQ12
    end
  end

  tnr_ram #(
    .AW (RAM_AW),
    .DW (8)
  ) u_ram (
    .pclk  (pclk),
    .we    (data_wr), // RQ11
    .addr  (addr),
    .wdata (pwdata[7:0]),
    .rdata (ram_rdata)
  );

  // ==========================================================
  // core control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake      <= 1'b0;
      join_net  <= 1'b0;
      cmd_valid <= 1'b0;
      cmd       <= tnr_pkg::ZERO8;
    end else begin
      wake      <= own_id != 8'h00; // RQ15
      join_net  <= (own_id != 8'h00) & cfg[tnr_pkg::CFG_TRANSMIT_ENABLE_BIT]; // RQ16
      cmd_valid <= wr_en & at(idx, tnr_pkg::IDX_CMD_DIAG);
      if (wr_en & at(idx, tnr_pkg::IDX_CMD_DIAG)) begin
        cmd <= pwdata[7:0];
      end
    end
  end

  assign core_ctl.wake        = wake;
  assign core_ctl.join_net    = join_net;
  assign core_ctl.cmd_valid   = cmd_valid;
  assign core_ctl.cmd         = cmd;
  assign core_ctl.probe_id    = probe_id;
  assign core_ctl.own_id      = own_id;
  assign core_ctl.config_bits = {cfg, wsel[1:0]};
  assign core_ctl.speed_setup_one      = speed_setup_one;
  assign core_ctl.timing_setup_two      = timing_setup_two;

  // ==========================================================
  // assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_irq_combine: assert property ( // RQ4
    intr == |$past(irq_src & imask)) else $error("irq mismatch");
  a_irq_source: assert property ( // RQ5
    intr |-> $past(|(irq_src & imask & tnr_pkg::IRQ_BITS)))
    else $error("irq from foreign flag");
  a_mask_reset: assert property ( // RQ10
    !$past(presetn) |-> imask == 8'h00) else $error("mask reset");
  a_recon_clear: assert property ( // RQ7
    clr_flags & !core_evt.recon |=> !recon) else $error("recon kept");
  a_excessive_nak_flag_hold: assert property ( // RQ8
    diag[tnr_pkg::DG_EXCESSIVE_NAK_FLAG] & !por_clr & !soft_rst
    |=> diag[tnr_pkg::DG_EXCESSIVE_NAK_FLAG]) else $error("excessive_nak_flag lost");
  a_next_clear: assert property ( // RQ9
    next_rd & !core_evt.next_upd & !soft_rst
    |=> !diag[tnr_pkg::DG_NEWNEXT]) else $error("new next kept");
  a_next_update: assert property ( // RQ18
    core_evt.next_upd & !soft_rst |=> diag[tnr_pkg::DG_NEWNEXT]
    && successor == $past(core_evt.successor_identity)) else $error("next upd");
  a_diag_rdclr: assert property ( // RQ21
    diag_rd & !soft_rst & !core_evt.myrecon & !core_evt.duplicate_identity_flag
    & !core_evt.rcvact & !core_evt.token & !core_evt.tent_hit
    |=> (diag & tnr_pkg::DIAG_RD_CLR) == 8'h00) else $error("diag rd");
  a_soft_reset: assert property ( // RQ20
    soft_rst |=> status_vec[7:2] == 6'h24 && successor == 8'h00
    && diag == 8'h00) else $error("soft reset values");
  a_core_dormant: assert property ( // RQ15
    own_id == 8'h00 |=> !wake ##0 !join_net) else $error("awake");
  a_join_transmit_enable_bit: assert property ( // RQ16
    join_net |-> $past(cfg[tnr_pkg::CFG_TRANSMIT_ENABLE_BIT])) else $error("join");
  a_ptr_load: assert property ( // RQ23
    lo_wr |=> addr[7:0] == $past(pwdata[7:0]) ##2 !fetch[1])
    else $error("pointer load");

  c_irq_rise: cover property ($rose(intr));
  c_next_read: cover property (next_rd);
  c_diag_read: cover property (diag_rd);
  c_data_fetch: cover property (lo_wr ##2 fetch[1]);

endmodule

// ==== tnr_pkg.sv ====
// constants and carrier types for the token node register bank
package tnr_pkg;

  // ==========================================================
  // register indices (byte address is four times the index)
  localparam logic [2:0] IDX_MASK_STAT = 3'h0;
  localparam logic [2:0] IDX_CMD_DIAG  = 3'h1;
  localparam logic [2:0] IDX_PTR_HI    = 3'h2;
  localparam logic [2:0] IDX_PTR_LO    = 3'h3;
  localparam logic [2:0] IDX_DATA      = 3'h4;
  localparam logic [2:0] IDX_WSEL      = 3'h5;
  localparam logic [2:0] IDX_CONFIG    = 3'h6;
  localparam logic [2:0] IDX_WINDOW    = 3'h7;

  // ==========================================================
  // window selections at index 7
  localparam logic [2:0] WIN_PROBE  = 3'h0;
  localparam logic [2:0] WIN_OWN    = 3'h1;
  localparam logic [2:0] WIN_SPEED_SETUP_ONE = 3'h2;
  localparam logic [2:0] WIN_NEXT   = 3'h3;
  localparam logic [2:0] WIN_TIMING_SETUP_TWO = 3'h4;

  // ==========================================================
  // field positions
  localparam int ST_RI      = 7;
  localparam int ST_POR     = 4;
  localparam int ST_RECON   = 2;
  localparam int ST_TMA     = 1;
  localparam int ST_TA      = 0;
  localparam int DG_MYRECON = 7;
  localparam int DG_DUPLICATE_IDENTITY_FLAG   = 6;
  localparam int DG_RCVACT  = 5;
  localparam int DG_TOKEN   = 4;
  localparam int DG_EXCESSIVE_NAK_FLAG  = 3;
  localparam int DG_TENT    = 2;
  localparam int DG_NEWNEXT = 1;
  localparam int CFG_RESET  = 7;
  localparam int CFG_TRANSMIT_ENABLE_BIT   = 5;
  localparam int PTR_INC    = 6;

  // ==========================================================
  // masks, reset values and command codes
  localparam logic [7:0] IRQ_BITS    = 8'h8F;
  localparam logic [7:0] DIAG_RD_CLR = 8'hF4;
  localparam logic [7:0] STATUS_RST  = 8'h91;
  localparam logic [7:0] DIAG_RST    = 8'h00;
  localparam logic [7:0] CONFIG_RST  = 8'h18;
  localparam logic [7:0] ZERO8       = 8'h00;
  localparam logic [7:0] CMD_CLR_FLG = 8'h06;
  localparam logic [7:0] CMD_POR_CLR = 8'h0E;
  localparam logic [1:0] FETCH_IDLE  = 2'h0;

  // events reported by the protocol core, one-cycle pulses except the tma level
  typedef struct packed {
    logic       ri_set;
    logic       ri_clr;
    logic       ta_set;
    logic       ta_clr;
    logic       tma;
    logic       recon;
    logic       myrecon;
    logic       duplicate_identity_flag;
    logic       rcvact;
    logic       token;
    logic       excessive_nak_flag;
    logic       tent_hit;
    logic       next_upd;
    logic [7:0] successor_identity;
  } tnr_core_evt_t;

  // settings driven to the protocol core
  typedef struct packed {
    logic       wake;
    logic       join_net;
    logic       cmd_valid;
    logic [7:0] cmd;
    logic [7:0] probe_id;
    logic [7:0] own_id;
    logic [7:0] config_bits;
    logic [7:0] speed_setup_one;
    logic [7:0] timing_setup_two;
  } tnr_core_ctl_t;

endpackage

// ==== tnr_ram.sv ====
// single port node ram with registered read data
`timescale 1ns/1ps
module tnr_ram #(
  parameter int AW = 11,
  parameter int DW = 8
) (
  input  wire logic          pclk,   // bus clock
  input  wire logic          we,     // write strobe
  input  wire logic [AW-1:0] addr,   // word address
  input  wire logic [DW-1:0] wdata,  // write data
  output      logic [DW-1:0] rdata   // read data, one cycle late
);

  logic [DW-1:0] mem [2**AW];

  // write and registered read, old data on collision
  always_ff @(posedge pclk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end

endmodule

// ==== tnr_core_model.sv ====
// behavioural model of the protocol core beside the register bank
`timescale 1ns/1ps
module tnr_core_model (
  input  wire tnr_pkg::tnr_core_ctl_t ctl,  // settings from the bank
  input  wire logic                   pclk, // bus clock
  output      tnr_pkg::tnr_core_evt_t evt   // event pulses to the bank
);
  // ==========================================================
  // event driving
  logic tma_lvl;

  // idle: no pulses, transmitter not mid-message
  initial begin
    tma_lvl = 1'b0;
    evt = '0;
  end

  // one cycle of events; a dormant core reports no token or recon
  task automatic fire(input logic [12:0] f, input logic [7:0] id);
    logic [12:0] g;
    g = f;
    if (ctl.wake !== 1'b1) g = g & 13'h1F37;
    g[8] = tma_lvl;
    @(posedge pclk);
    evt <= tnr_pkg::tnr_core_evt_t'({g, id});
    @(posedge pclk);
    evt <= tnr_pkg::tnr_core_evt_t'({4'h0, tma_lvl, 8'h00, 8'h00});
  endtask

  // traffic from a node: flag a hit when it matches the probe
  task automatic hear(input logic [7:0] id);
    if (id === ctl.probe_id) fire(13'h0002, 8'h00);
  endtask
endmodule

// ==== tnr_tb.sv ====
// self-checking bench for the token node register bank
`timescale 1ns/1ps
module testbench;
  logic                   pclk, presetn, psel, penable, pwrite;
  logic                   pready, pslverr, intr, last_err;
  logic [11:0]            paddr;
  logic [31:0]            pwdata, prdata;
  tnr_pkg::tnr_core_evt_t evt;
  tnr_pkg::tnr_core_ctl_t ctl;
  int                     bad_count, checks;
  localparam logic [12:0] EV_RX_CLR = 13'h0800;
  localparam logic [12:0] EV_TX_CLR = 13'h0200;
  localparam logic [12:0] EV_RECON  = 13'h0080;
  localparam logic [12:0] EV_NAK    = 13'h0004;
  localparam logic [12:0] EV_NEXT   = 13'h0001;
  localparam logic [12:0] EV_DIAG   = 13'h007A;

  tnr_reg_bank uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .core_evt(evt), .core_ctl(ctl), .intr(intr));
  tnr_core_model core (.ctl(ctl), .pclk(pclk), .evt(evt));

  // ==========================================================
  // bus and comparison helpers
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata[7:0];
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [7:0] x;
    apb(1'b1, a, d, x);
  endtask

  task automatic rc(input logic [11:0] a, input logic [7:0] e);
    logic [7:0] x;
    apb(1'b0, a, 8'h00, x);
    chk(x, e);
  endtask

  // lets the registered interrupt settle, then compares it
  task automatic irq(input logic e);
    repeat (3) @(posedge pclk);
    chk({7'h00, intr}, {7'h00, e});
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    rc(12'h000, tnr_pkg::STATUS_RST);
    rc(12'h004, 8'h00);
    irq(1'b0);
    rc(12'h018, 8'h18);
    wr(12'h014, 8'h03);
    rc(12'h01C, 8'h00);
    wr(12'h014, 8'h01);
    rc(12'h01C, 8'h00);
  endtask

  task automatic t_ident();
    chk({7'h00, ctl.wake}, 8'h00);
    wr(12'h01C, 8'h21);
    wr(12'h014, 8'h00);
    wr(12'h01C, 8'h33);
    rc(12'h01C, 8'h33);
    chk(ctl.probe_id, 8'h33);
    wr(12'h014, 8'h01);
    rc(12'h01C, 8'h21);
    wr(12'h014, 8'h02);
    wr(12'h01C, 8'h0A);
    rc(12'h01C, 8'h0A);
    wr(12'h014, 8'h04);
    wr(12'h01C, 8'h8D);
    rc(12'h01C, 8'h8D);
    chk({6'h00, ctl.wake, ctl.join_net}, 8'h02);
    wr(12'h018, 8'h38);
    repeat (2) @(posedge pclk);
    chk({6'h00, ctl.wake, ctl.join_net}, 8'h03);
    core.hear(8'h33);
    rc(12'h004, 8'h04);
  endtask

  task automatic t_mask();
    logic [7:0] m;
    for (int i = 0; i < 2; i++) begin
      m = (i == 0) ? 8'h80 : 8'h01;
      wr(12'h000, m);
      irq(1'b1);
      wr(12'h000, 8'h00);
      irq(1'b0);
      wr(12'h000, m);
      irq(1'b1);
      core.fire((i == 0) ? EV_RX_CLR : EV_TX_CLR, 8'h00);
      irq(1'b0);
    end
  endtask

  task automatic t_flags();
    wr(12'h000, 8'h0E);
    core.fire(EV_DIAG, 8'h00);
    irq(1'b0);
    rc(12'h004, tnr_pkg::DIAG_RD_CLR);
    rc(12'h004, 8'h00);
    wr(12'h000, 8'h08);
    core.fire(EV_NAK, 8'h00);
    irq(1'b1);
    rc(12'h004, 8'h08);
    rc(12'h004, 8'h08);
    wr(12'h004, tnr_pkg::CMD_CLR_FLG);
    irq(1'b1);
    wr(12'h004, tnr_pkg::CMD_POR_CLR);
    irq(1'b0);
    chk(ctl.cmd, tnr_pkg::CMD_POR_CLR);
    wr(12'h000, 8'h04);
    core.fire(EV_RECON, 8'h00);
    irq(1'b1);
    rc(12'h000, 8'h04);
    wr(12'h004, tnr_pkg::CMD_CLR_FLG);
    irq(1'b0);
  endtask

  task automatic t_next();
    wr(12'h000, 8'h02);
    core.fire(EV_NEXT, 8'h5A);
    irq(1'b1);
    rc(12'h004, 8'h02);
    rc(12'h004, 8'h02);
    wr(12'h014, 8'h03);
    rc(12'h01C, 8'h5A);
    irq(1'b0);
    rc(12'h004, 8'h00);
  endtask

  task automatic t_ram();
    wr(12'h008, 8'h01);
    wr(12'h00C, 8'h20);
    wr(12'h010, 8'hA5);
    wr(12'h00C, 8'h20);
    rc(12'h010, 8'hA5);
    wr(12'h008, 8'h41);
    wr(12'h00C, 8'h30);
    wr(12'h010, 8'h11);
    wr(12'h010, 8'h22);
    wr(12'h008, 8'h41);
    wr(12'h00C, 8'h30);
    rc(12'h010, 8'h11);
    rc(12'h010, 8'h22);
  endtask

  task automatic t_soft();
    rc(12'h020, 8'h00);
    chk({7'h00, last_err}, 8'h01);
    core.fire(EV_NAK, 8'h00);
    wr(12'h018, 8'h9B);
    rc(12'h000, tnr_pkg::STATUS_RST);
    rc(12'h004, 8'h00);
    rc(12'h01C, 8'h00);
    wr(12'h018, 8'h19);
    rc(12'h01C, 8'h21);
  endtask

  // ==========================================================
  // verdict, reached from the main sequence or the watchdog
  task automatic conclude();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // free running bus clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // hang guard, far beyond the few hundred cycles needed
  initial begin
    #200000;
    bad_count++;
    conclude();
  end

  // reset, then the scenarios in turn
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, last_err} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    bad_count = 0;
    checks = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_ident();
    t_mask();
    t_flags();
    t_next();
    t_ram();
    t_soft();
    conclude();
  end
endmodule
